// File: common/hbdfc_pkg.sv
/*
  Shared constants and types of the H-bridge drive and fault control block.
  Assumes a single 50 MHz clock; every timing count is derived from it here.
*/
package hbdfc_pkg;

  // ----------------------------------------
  // Clock and PWM timebase
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int PWM_FREQ_HZ = 44_500;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
  localparam int DUTY_W = 11;

  // ----------------------------------------
  // Soft start, protection and pulse timing
  // ----------------------------------------
  localparam int RAMP_FULL_MS = 12;
  localparam int RAMP_STEP_CYC = (RAMP_FULL_MS * (CLK_HZ / 1000)) / PWM_PERIOD_CYC;
  localparam int CL_DEGLITCH_NS = 3000;
  localparam int CL_DEGLITCH_CYC = (CL_DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int CL_FAULT_MS = 275;
  localparam int CL_FAULT_CYC = CL_FAULT_MS * (CLK_HZ / 1000);
  localparam int CL_CNT_W = 24;
  localparam int OCP_DEGLITCH_NS = 2000;
  localparam int OCP_DEGLITCH_CYC = (OCP_DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int EXIT_PULSE_NS = 1000;
  localparam int EXIT_PULSE_CYC = (EXIT_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W = 8;
  localparam int CL_DUTY_STEP = 16;

  // ----------------------------------------
  // Regulation data path
  // ----------------------------------------
  localparam int SENSE_W = 10;
  localparam int SET_W = 8;
  localparam int AVG_SHIFT = 4;
  localparam int SCALE_SHIFT = 2;
  localparam int AVG_W = SENSE_W + AVG_SHIFT;
  localparam int SWITCH_N = 4;

  typedef enum logic [3:0] {
    ST_SLEEP = 4'h1,
    ST_RUN = 4'h2,
    ST_BRAKE = 4'h4,
    ST_LATCHED = 4'h8
  } hbdfc_state_e;

endpackage

// File: rtl/hbdfc_pwm.sv
/*
  PWM timebase: free-running period counter with on-phase compare.
  Assumes duty is held stable by the caller and restart is a one-cycle pulse.
*/
module hbdfc_pwm #(
  parameter int PERIOD = hbdfc_pkg::PWM_PERIOD_CYC,
  parameter int W = hbdfc_pkg::DUTY_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic [W-1:0] duty,
  output logic pwm_on,
  output logic period_end
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic on_q;
  logic on_d;
  logic end_q;
  logic end_d;

  always_comb
  begin
    end_d = (cnt_q == W'(PERIOD - 1));
    if (restart || end_d)
      cnt_d = '0;
    else
      cnt_d = cnt_q + W'(1);
    on_d = restart ? 1'b0 : (cnt_d < duty);
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      on_q <= 1'b0;
      end_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      on_q <= on_d;
      end_q <= end_d;
    end
  end

  assign pwm_on = on_q;
  assign period_end = end_q;

endmodule

// File: rtl/hbdfc_sync.sv
/*
  Two flip-flop synchroniser for pin inputs.
  Assumes multi-bit inputs change slowly compared with the clock.
*/
module hbdfc_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule

// File: rtl/hbdfc_top.sv
/*
  H-bridge drive and fault control: direction decode, sleep, soft-start PWM
  voltage regulation, current limit, latched short protection, overheat and
  low-supply handling, and the active-low fault output.
  Assumes analog sensing arrives as digital levels and codes on pins.
*/

module hbdfc_top #(
  parameter int CL_FAULT_CYC = hbdfc_pkg::CL_FAULT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic dir_input_a,
  input wire logic dir_input_b,
  input wire logic [hbdfc_pkg::SET_W-1:0] speed_setpoint,
  input wire logic [hbdfc_pkg::SENSE_W-1:0] out_diff_level,
  input wire logic current_sense_pin,
  input wire logic level_above_supply,
  input wire logic [hbdfc_pkg::SWITCH_N-1:0] short_protect,
  input wire logic overheat_shutdown,
  input wire logic low_supply_lockout,
  output logic bridge_out_a,
  output logic bridge_out_a_oe,
  output logic bridge_out_b,
  output logic bridge_out_b_oe,
  output logic fault_flag_low
);

  localparam int DW = hbdfc_pkg::DUTY_W;
  localparam int TW = hbdfc_pkg::TMR_W;
  localparam int CW = hbdfc_pkg::CL_CNT_W;
  localparam logic [DW-1:0] FULL = DW'(hbdfc_pkg::PWM_PERIOD_CYC);

  function automatic logic [DW-1:0] dmin(input logic [DW-1:0] x, input logic [DW-1:0] y);
    dmin = (x < y) ? x : y;
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [hbdfc_pkg::SET_W-1:0] set_s;
  logic [hbdfc_pkg::SENSE_W-1:0] diff_s;
  logic [hbdfc_pkg::SWITCH_N-1:0] short_s;
  logic [5:0] lvl_s;
  logic dir_a_s;
  logic dir_b_s;
  logic sense_s;
  logic sat_s;
  logic tsd_s;
  logic low_supply_lockout_s;

  hbdfc_sync #(.W(hbdfc_pkg::SET_W)) u_sync_set (
    .ref_clk(ref_clk), .rst_n(rst_n), .din(speed_setpoint), .dout(set_s));
  hbdfc_sync #(.W(hbdfc_pkg::SENSE_W)) u_sync_diff (
    .ref_clk(ref_clk), .rst_n(rst_n), .din(out_diff_level), .dout(diff_s));
  hbdfc_sync #(.W(hbdfc_pkg::SWITCH_N)) u_sync_short (
    .ref_clk(ref_clk), .rst_n(rst_n), .din(short_protect), .dout(short_s));
  hbdfc_sync #(.W(6)) u_sync_lvl (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .din({dir_input_a, dir_input_b, current_sense_pin, level_above_supply,
          overheat_shutdown, low_supply_lockout}),
    .dout(lvl_s));

  assign dir_a_s = lvl_s[5];
  assign dir_b_s = lvl_s[4];
  assign sense_s = lvl_s[3];
  assign sat_s = lvl_s[2];
  assign tsd_s = lvl_s[1];
  assign low_supply_lockout_s = lvl_s[0];

  // ----------------------------------------
  // Mode, soft start and regulation
  // ----------------------------------------
  hbdfc_pkg::hbdfc_state_e state_q;
  hbdfc_pkg::hbdfc_state_e state_d;
  logic [DW-1:0] duty_q;
  logic [DW-1:0] duty_d;
  logic [DW-1:0] ramp_q;
  logic [DW-1:0] ramp_d;
  logic [DW-1:0] eff_q;
  logic [DW-1:0] eff_d;
  logic [9:0] ramp_cnt_q;
  logic [9:0] ramp_cnt_d;
  logic [hbdfc_pkg::AVG_W-1:0] avg_q;
  logic [hbdfc_pkg::AVG_W-1:0] avg_d;
  logic [TW-1:0] pulse_q;
  logic [TW-1:0] pulse_d;
  logic [hbdfc_pkg::SET_W-1:0] scaled;
  logic mode_sleep;
  logic mode_brake;
  logic start_run;
  logic ocp_trip;
  logic cl_on_q;
  logic pwm_on;
  logic period_end;

  assign mode_sleep = !dir_a_s && !dir_b_s;
  assign mode_brake = dir_a_s && dir_b_s;
  assign scaled = avg_q[hbdfc_pkg::AVG_W-1 -: hbdfc_pkg::SET_W];

  always_comb
  begin
    state_d = state_q;
    pulse_d = (pulse_q != '0) ? pulse_q - TW'(1) : pulse_q;
    case (state_q)
      hbdfc_pkg::ST_SLEEP:
      begin
        if (!mode_sleep)
        begin
          state_d = mode_brake ? hbdfc_pkg::ST_BRAKE : hbdfc_pkg::ST_RUN;
          pulse_d = TW'(hbdfc_pkg::EXIT_PULSE_CYC);
        end
      end
      hbdfc_pkg::ST_RUN:
      begin
        if (mode_sleep)
          state_d = hbdfc_pkg::ST_SLEEP;
        else if (mode_brake)
          state_d = hbdfc_pkg::ST_BRAKE;
      end
      hbdfc_pkg::ST_BRAKE:
      begin
        if (mode_sleep)
          state_d = hbdfc_pkg::ST_SLEEP;
        else if (!mode_brake)
          state_d = hbdfc_pkg::ST_RUN;
      end
      hbdfc_pkg::ST_LATCHED:
      begin
        state_d = hbdfc_pkg::ST_LATCHED;
      end
      default:
      begin
        state_d = hbdfc_pkg::ST_SLEEP;
      end
    endcase
    if (ocp_trip)
      state_d = hbdfc_pkg::ST_LATCHED;
    if (low_supply_lockout_s)
    begin
      state_d = hbdfc_pkg::ST_SLEEP;
      pulse_d = '0;
    end
    start_run = (state_d == hbdfc_pkg::ST_RUN) && (state_q != hbdfc_pkg::ST_RUN);
    avg_d = avg_q + hbdfc_pkg::AVG_W'(diff_s) - (avg_q >> hbdfc_pkg::AVG_SHIFT);
    duty_d = duty_q;
    ramp_d = ramp_q;
    ramp_cnt_d = ramp_cnt_q;
    if (start_run)
    begin
      duty_d = '0;
      ramp_d = '0;
      ramp_cnt_d = '0;
    end
    else if (state_q == hbdfc_pkg::ST_RUN)
    begin
      if (ramp_q < FULL)
      begin
        if (ramp_cnt_q == 10'(hbdfc_pkg::RAMP_STEP_CYC - 1))
        begin
          ramp_cnt_d = '0;
          ramp_d = ramp_q + DW'(1);
        end
        else
          ramp_cnt_d = ramp_cnt_q + 10'(1);
      end
      if (period_end)
      begin
        if (cl_on_q)
          duty_d = (duty_q > DW'(hbdfc_pkg::CL_DUTY_STEP)) ? duty_q - DW'(hbdfc_pkg::CL_DUTY_STEP) : '0;
        else if (sat_s)
          duty_d = FULL;
        else if ((scaled < set_s) && (duty_q < FULL))
          duty_d = duty_q + DW'(1);
        else if ((scaled > set_s) && (duty_q != '0))
          duty_d = duty_q - DW'(1);
      end
    end
    eff_d = dmin(duty_d, ramp_d);
    if (low_supply_lockout_s)
    begin
      duty_d = '0;
      ramp_d = '0;
      eff_d = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= hbdfc_pkg::ST_SLEEP;
      duty_q <= '0;
      ramp_q <= '0;
      eff_q <= '0;
      ramp_cnt_q <= '0;
      avg_q <= '0;
      pulse_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      duty_q <= duty_d;
      ramp_q <= ramp_d;
      eff_q <= eff_d;
      ramp_cnt_q <= ramp_cnt_d;
      avg_q <= avg_d;
      pulse_q <= pulse_d;
    end
  end

  hbdfc_pwm #(.PERIOD(hbdfc_pkg::PWM_PERIOD_CYC), .W(DW)) u_pwm (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .restart(start_run),
    .duty(eff_q),
    .pwm_on(pwm_on),
    .period_end(period_end)
  );

  // ----------------------------------------
  // Current limit and short protection
  // ----------------------------------------
  logic [TW-1:0] cl_deg_q;
  logic [TW-1:0] cl_deg_d;
  logic cl_on_d;
  logic [CW-1:0] cl_cnt_q;
  logic [CW-1:0] cl_cnt_d;
  logic cl_fault_q;
  logic cl_fault_d;
  logic [TW-1:0] ocp_cnt_q;
  logic [TW-1:0] ocp_cnt_d;
  logic ocp_latch_q;
  logic ocp_latch_d;

  assign ocp_trip = (|short_s) && (ocp_cnt_q == TW'(hbdfc_pkg::OCP_DEGLITCH_CYC));

  always_comb
  begin
    cl_deg_d = '0;
    if (sense_s && (state_q == hbdfc_pkg::ST_RUN))
      cl_deg_d = (cl_deg_q == TW'(hbdfc_pkg::CL_DEGLITCH_CYC)) ? cl_deg_q : cl_deg_q + TW'(1);
    cl_on_d = (cl_deg_d == TW'(hbdfc_pkg::CL_DEGLITCH_CYC));
    cl_cnt_d = '0;
    cl_fault_d = 1'b0;
    if (cl_on_q)
    begin
      cl_cnt_d = (cl_cnt_q == CW'(CL_FAULT_CYC)) ? cl_cnt_q : cl_cnt_q + CW'(1);
      cl_fault_d = (cl_cnt_q == CW'(CL_FAULT_CYC));
    end
    ocp_cnt_d = '0;
    if (|short_s)
      ocp_cnt_d = ocp_trip ? ocp_cnt_q : ocp_cnt_q + TW'(1);
    ocp_latch_d = ocp_latch_q || ocp_trip;
    if (low_supply_lockout_s || state_q == hbdfc_pkg::ST_SLEEP)
    begin
      cl_deg_d = '0;
      cl_on_d = 1'b0;
      cl_cnt_d = '0;
      cl_fault_d = 1'b0;
    end
    if (low_supply_lockout_s)
    begin
      ocp_cnt_d = '0;
      ocp_latch_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cl_deg_q <= '0;
      cl_on_q <= 1'b0;
      cl_cnt_q <= '0;
      cl_fault_q <= 1'b0;
      ocp_cnt_q <= '0;
      ocp_latch_q <= 1'b0;
    end
    else
    begin
      cl_deg_q <= cl_deg_d;
      cl_on_q <= cl_on_d;
      cl_cnt_q <= cl_cnt_d;
      cl_fault_q <= cl_fault_d;
      ocp_cnt_q <= ocp_cnt_d;
      ocp_latch_q <= ocp_latch_d;
    end
  end

  // ----------------------------------------
  // Bridge pins and fault output
  // ----------------------------------------
  logic a_d;
  logic aoe_d;
  logic b_d;
  logic boe_d;
  logic fault_d;
  logic off_all;

  assign off_all = tsd_s || low_supply_lockout_s || ocp_latch_q || (state_q == hbdfc_pkg::ST_LATCHED);

  always_comb
  begin
    a_d = 1'b0;
    b_d = 1'b0;
    aoe_d = 1'b0;
    boe_d = 1'b0;
    if (!off_all && (state_q == hbdfc_pkg::ST_BRAKE))
    begin
      a_d = 1'b1;
      b_d = 1'b1;
      aoe_d = 1'b1;
      boe_d = 1'b1;
    end
    else if (!off_all && (state_q == hbdfc_pkg::ST_RUN))
    begin
      aoe_d = 1'b1;
      boe_d = 1'b1;
      a_d = !pwm_on || dir_a_s;
      b_d = !pwm_on || dir_b_s;
    end
    fault_d = !(cl_fault_q || ocp_latch_q || tsd_s || low_supply_lockout_s || (pulse_q != '0));
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bridge_out_a <= 1'b0;
      bridge_out_a_oe <= 1'b0;
      bridge_out_b <= 1'b0;
      bridge_out_b_oe <= 1'b0;
      fault_flag_low <= 1'b1;
    end
    else
    begin
      bridge_out_a <= a_d;
      bridge_out_a_oe <= aoe_d;
      bridge_out_b <= b_d;
      bridge_out_b_oe <= boe_d;
      fault_flag_low <= fault_d;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_sleep_outputs_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == hbdfc_pkg::ST_SLEEP) |=> (!bridge_out_a_oe && !bridge_out_b_oe))
    else $error("Bridge driven while asleep.");
  a_brake_both_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == hbdfc_pkg::ST_BRAKE && !off_all) |=> (bridge_out_a && bridge_out_b && bridge_out_a_oe))
    else $error("Brake does not drive both outputs high.");
  a_offphase_recirc: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == hbdfc_pkg::ST_RUN && !off_all && !pwm_on) |=> (bridge_out_a && bridge_out_b))
    else $error("Off phase does not recirculate through high sides.");
  a_ramp_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q != hbdfc_pkg::ST_RUN ##1 state_q == hbdfc_pkg::ST_RUN) |-> (eff_q == '0 && ramp_q == '0))
    else $error("Soft start did not restart at zero duty.");
  a_exit_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == hbdfc_pkg::ST_SLEEP && !mode_sleep && !low_supply_lockout_s) |=> ##1 !fault_flag_low [*3])
    else $error("No fault pulse on sleep exit.");
  a_cl_fault_sleep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == hbdfc_pkg::ST_SLEEP) |=> !cl_fault_q)
    else $error("Current-limit fault kept through sleep.");
  a_ocp_latched: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ocp_latch_q && !low_supply_lockout_s) |=> (ocp_latch_q && !fault_flag_low && !bridge_out_a_oe))
    else $error("Short protection latch released or bridge driven.");
  a_tsd_disable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tsd_s |=> (!bridge_out_a_oe && !bridge_out_b_oe && !fault_flag_low))
    else $error("Overheat did not disable bridge.");
  a_low_supply_lockout_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    low_supply_lockout_s |=> (!fault_flag_low && state_q == hbdfc_pkg::ST_SLEEP && !ocp_latch_q))
    else $error("Low supply did not reset logic.");
  a_fault_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!cl_fault_q && !ocp_latch_q && !tsd_s && !low_supply_lockout_s && pulse_q == '0) |=> fault_flag_low)
    else $error("Fault output low with no cause.");

endmodule

// File: testbench/hbdfc_host.sv
/*
  Host model that drives the two direction inputs and watches the fault output.
  Assumes the bench calls set_dir and reads pulse_cnt hierarchically.
*/
module hbdfc_host (
  input wire logic ref_clk,
  input wire logic fault_flag_low,
  output logic dir_input_a,
  output logic dir_input_b
);
  timeunit 1ns;
  timeprecision 1ps;

  int pulse_cnt = 0;

  initial
  begin
    dir_input_a = 1'b0;
    dir_input_b = 1'b0;
  end

  // ----------------------------------------
  // Direction levels change only on request, as steady levels.
  // ----------------------------------------
  task automatic set_dir(input logic a, input logic b);
    @(negedge ref_clk);
    dir_input_a = a;
    dir_input_b = b;
  endtask

  // ----------------------------------------
  // Counts low pulses seen on the fault output.
  // ----------------------------------------
  always @(negedge fault_flag_low)
  begin
    pulse_cnt++;
  end
endmodule

// File: testbench/hbridge_drive_fault_control_test.sv
/*
  Self-checking bench for the H-bridge drive and fault control block.
  Assumes the host model drives the direction pins; sensing pins are driven here.
*/
module hbridge_drive_fault_control_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic dir_input_a, dir_input_b;
  logic [hbdfc_pkg::SET_W-1:0] speed_setpoint = 8'h00;
  logic [hbdfc_pkg::SENSE_W-1:0] out_diff_level = 10'h000;
  logic current_sense_pin = 1'b0;
  logic level_above_supply = 1'b1;
  logic [hbdfc_pkg::SWITCH_N-1:0] short_protect = 4'h0;
  logic overheat_shutdown = 1'b0;
  logic low_supply_lockout = 1'b0;
  logic bridge_out_a, bridge_out_a_oe, bridge_out_b, bridge_out_b_oe, fault_flag_low;
  int error_cnt = 0;
  int checked = 0;
  int on_n;
  logic [1:0] on_val;

  always #10 ref_clk = ~ref_clk;

  hbdfc_top #(.CL_FAULT_CYC(200)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .dir_input_a(dir_input_a), .dir_input_b(dir_input_b),
    .speed_setpoint(speed_setpoint), .out_diff_level(out_diff_level),
    .current_sense_pin(current_sense_pin), .level_above_supply(level_above_supply),
    .short_protect(short_protect), .overheat_shutdown(overheat_shutdown),
    .low_supply_lockout(low_supply_lockout), .bridge_out_a(bridge_out_a),
    .bridge_out_a_oe(bridge_out_a_oe), .bridge_out_b(bridge_out_b),
    .bridge_out_b_oe(bridge_out_b_oe), .fault_flag_low(fault_flag_low)
  );

  hbdfc_host i_host (
    .ref_clk(ref_clk), .fault_flag_low(fault_flag_low),
    .dir_input_a(dir_input_a), .dir_input_b(dir_input_b)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic go(input logic a, input logic b);
    i_host.set_dir(a, b);
    wait_cyc(5);
  endtask

  // Counts on-phase cycles, where a driven bridge is not in the both-high state.
  task automatic scan(input int n, output int cnt, output logic [1:0] val);
    cnt = 0;
    val = 2'b11;
    repeat (n)
    begin
      @(negedge ref_clk);
      if (bridge_out_a_oe && !(bridge_out_a && bridge_out_b))
      begin
        cnt++;
        val = {bridge_out_a, bridge_out_b};
      end
    end
  endtask

  task automatic wait_fault_low(input int n);
    int k;
    k = 0;
    while (fault_flag_low !== 1'b0 && k < n)
    begin
      @(negedge ref_clk);
      k++;
    end
  endtask

  task automatic print_verdict;
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    check({bridge_out_a_oe, bridge_out_b_oe}, 2'b00);
    check(fault_flag_low, 1'b1);
  endtask

  task automatic t_decode;
    int p0, low_n;
    p0 = i_host.pulse_cnt;
    low_n = 0;
    i_host.set_dir(1'b1, 1'b0);
    repeat (80)
    begin
      @(negedge ref_clk);
      if (fault_flag_low === 1'b0)
        low_n++;
    end
    check(low_n, hbdfc_pkg::EXIT_PULSE_CYC);
    check(i_host.pulse_cnt - p0, 1);
    scan(400, on_n, on_val);
    check(on_n, 0);
    check({bridge_out_a_oe, bridge_out_b_oe}, 2'b11);
    wait_cyc(6000);
    scan(1200, on_n, on_val);
    check(on_n > 0, 1'b1);
    check(on_val, 2'b10);
    go(1'b0, 1'b1);
    scan(1200, on_n, on_val);
    check(on_val, 2'b01);
    go(1'b1, 1'b1);
    scan(1200, on_n, on_val);
    check(on_n, 0);
    check({bridge_out_a_oe, bridge_out_b_oe, bridge_out_a, bridge_out_b}, 4'hF);
    i_host.set_dir(1'b1, 1'b0);
    scan(405, on_n, on_val);
    check(on_n, 0);
    go(1'b0, 1'b0);
    check({bridge_out_a_oe, bridge_out_b_oe}, 2'b00);
    check(i_host.pulse_cnt - p0, 1);
  endtask

  task automatic t_regulate;
    level_above_supply = 1'b0;
    speed_setpoint = 8'h00;
    out_diff_level = 10'h3FF;
    go(1'b1, 1'b0);
    wait_cyc(6000);
    scan(1200, on_n, on_val);
    check(on_n, 0);
    speed_setpoint = 8'hFF;
    out_diff_level = 10'h000;
    wait_cyc(15000);
    scan(1200, on_n, on_val);
    check(on_n > 0, 1'b1);
    speed_setpoint = 8'h00;
    out_diff_level = 10'h3FF;
    wait_cyc(20000);
    scan(1200, on_n, on_val);
    check(on_n, 0);
    level_above_supply = 1'b1;
    wait_cyc(2500);
    scan(1200, on_n, on_val);
    check(on_n > 0, 1'b1);
    go(1'b0, 1'b0);
  endtask

  task automatic t_limit;
    go(1'b1, 1'b0);
    wait_cyc(100);
    current_sense_pin = 1'b1;
    wait_fault_low(1000);
    check(fault_flag_low, 1'b0);
    check({bridge_out_a_oe, bridge_out_b_oe}, 2'b11);
    current_sense_pin = 1'b0;
    wait_cyc(20);
    check(fault_flag_low, 1'b1);
    current_sense_pin = 1'b1;
    wait_fault_low(1000);
    check(fault_flag_low, 1'b0);
    go(1'b0, 1'b0);
    check(fault_flag_low, 1'b1);
    current_sense_pin = 1'b0;
  endtask

  task automatic t_heat;
    go(1'b1, 1'b1);
    wait_cyc(100);
    overheat_shutdown = 1'b1;
    wait_cyc(5);
    check({fault_flag_low, bridge_out_a_oe, bridge_out_b_oe}, 3'b000);
    overheat_shutdown = 1'b0;
    wait_cyc(5);
    check({fault_flag_low, bridge_out_a_oe, bridge_out_b_oe}, 3'b111);
    go(1'b0, 1'b0);
  endtask

  task automatic t_short;
    for (int i = 0; i < hbdfc_pkg::SWITCH_N; i++)
    begin
      go(1'b1, 1'b1);
      wait_cyc(100);
      short_protect = 4'h1 << i;
      wait_cyc(120);
      short_protect = 4'h0;
      wait_cyc(5);
      check({fault_flag_low, bridge_out_a_oe, bridge_out_b_oe}, 3'b000);
      go(1'b0, 1'b1);
      wait_cyc(20);
      check({fault_flag_low, bridge_out_a_oe, bridge_out_b_oe}, 3'b000);
      low_supply_lockout = 1'b1;
      wait_cyc(5);
      check({fault_flag_low, bridge_out_a_oe, bridge_out_b_oe}, 3'b000);
      low_supply_lockout = 1'b0;
      wait_cyc(10);
      check({bridge_out_a_oe, bridge_out_b_oe}, 2'b11);
      go(1'b0, 1'b0);
    end
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    wait_cyc(4);
    rst_n = 1'b1;
    wait_cyc(2);
    t_reset();
    t_decode();
    t_regulate();
    t_limit();
    t_heat();
    t_short();
    print_verdict();
  end

  initial
  begin
    #2_000_000;
    error_cnt++;
    print_verdict();
  end
endmodule
